//--- common/sef_pkg.sv
// Package for the serial EEPROM front end: sizes, counts and carriers.
// Assumes a single core clock domain; all pins are sampled into it.
package sef_pkg;
  localparam int ARRAY_DEPTH = 1024;
  localparam int ARRAY_ADDR_W = 10;
  localparam int IDPAGE_DEPTH = 32;
  localparam int IDPAGE_ADDR_W = 5;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // Serial pins as seen from the device side.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic sel_n;
    logic pause_n;
    logic wprot_n;
  } sef_pins_s;

  // Byte stream towards the command logic.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sef_byte_s;
endpackage

//--- verilog/sef_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/10ps
module sef_sync (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Pin and filtered level.
  input wire logic pin_i,
  output logic level_o
);
  import sef_pkg::*;
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  // Only stage 1 feeds stage 2; the level moves once stages 2 and 3 agree.
  always_comb begin
    stage_next = {stage_reg[1:0], pin_i};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  // Reset high so an idle select or pause reads inactive.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_reg <= SYNC_RST;
      level_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule // sef_sync

//--- verilog/sef_front_end.sv
// Serial front end of a small SPI EEPROM: pin sampling, framing, shifting.
// Assumes the command logic sits behind the byte ports on core_clk_i.
`timescale 1ns/10ps
module sef_front_end (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Serial pins from the master.
  input sef_pkg::sef_pins_s pins_i,
  // Serial data output pin.
  output logic miso_o,
  output logic miso_oe_o,
  // Byte streams to and from command logic.
  output sef_pkg::sef_byte_s rx_byte_o,
  input wire logic [7:0] tx_byte_i,
  output logic tx_load_o,
  // Command logic controls and status.
  input wire logic write_busy_i,
  input wire logic id_lock_i,
  output logic id_locked_o,
  output logic selected_o,
  output logic active_power_o,
  output logic frame_start_o,
  output logic frame_end_o,
  output logic wprot_n_o,
  // Identification page and main store access.
  input wire logic mem_we_i,
  input wire logic mem_id_i,
  input wire logic [9:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  import sef_pkg::*;

  logic sclk_s;
  logic mosi_s;
  logic sel_n_s;
  logic pause_n_s;
  logic wprot_s;
  sef_pins_s pin_vec;
  logic [4:0] lvl;

  // Every pin crosses into the core clock through its own synchroniser.
  assign pin_vec = pins_i;
  for (genvar g = 0; g < 5; g++) begin : g_sync
    sef_sync u_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pin_vec[g]),
      .level_o(lvl[g])
    );
  end
  assign wprot_s = lvl[0];
  assign pause_n_s = lvl[1];
  assign sel_n_s = lvl[2];
  assign mosi_s = lvl[3];
  assign sclk_s = lvl[4];

  logic sclk_reg, sclk_next;
  logic sel_n_reg, sel_n_next;
  logic armed_reg, armed_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sh_in_reg, sh_in_next;
  logic [7:0] sh_out_reg, sh_out_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic rxv_reg, rxv_next;
  logic [7:0] rxd_reg, rxd_next;
  logic first_reg, first_next;
  logic rise, fall, sel_fall, sel_rise, live;

  // Edges are found on the filtered levels; pause masks the clock.
  assign rise = live && sclk_s && !sclk_reg;
  assign fall = live && !sclk_s && sclk_reg;
  assign sel_fall = sel_n_reg && !sel_n_s;
  assign sel_rise = !sel_n_reg && sel_n_s;
  assign live = armed_reg && !sel_n_s && pause_n_s;

  // Framing, shift registers and output driver.
  always_comb begin
    sclk_next = sclk_s;
    sel_n_next = sel_n_s;
    armed_next = armed_reg;
    cnt_next = cnt_reg;
    sh_in_next = sh_in_reg;
    sh_out_next = sh_out_reg;
    out_next = out_reg;
    rxv_next = 1'b0;
    rxd_next = rxd_reg;
    first_next = first_reg;
    if (sel_fall) begin
      armed_next = 1'b1;
      first_next = 1'b1;
      cnt_next = BIT_CNT_RST;
    end
    if (sel_rise) begin
      cnt_next = BIT_CNT_RST;
    end
    if (rise) begin
      sh_in_next = {sh_in_reg[6:0], mosi_s};
      cnt_next = cnt_reg + 3'h1;
      if (cnt_reg == BIT_CNT_LAST) begin
        rxv_next = 1'b1;
        rxd_next = {sh_in_reg[6:0], mosi_s};
        first_next = 1'b0;
      end
    end
    if (fall) begin
      // A byte boundary reloads from the command logic, MSB first.
      if (cnt_reg == BIT_CNT_RST && !first_reg) begin
        out_next = tx_byte_i[7];
        sh_out_next = {tx_byte_i[6:0], 1'b0};
      end else begin
        out_next = sh_out_reg[7];
        sh_out_next = {sh_out_reg[6:0], 1'b0};
      end
    end
    // Released when deselected, paused, or not yet armed.
    oe_next = live;
  end

  // Registers of the framing state.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_reg <= 1'b1; // Matches the synchroniser's reset level.
      sel_n_reg <= 1'b1;
      armed_reg <= 1'b0;
      cnt_reg <= BIT_CNT_RST;
      sh_in_reg <= BYTE_RST;
      sh_out_reg <= BYTE_RST;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxd_reg <= BYTE_RST;
      first_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk_next;
      sel_n_reg <= sel_n_next;
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      sh_in_reg <= sh_in_next;
      sh_out_reg <= sh_out_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      rxv_reg <= rxv_next;
      rxd_reg <= rxd_next;
      first_reg <= first_next;
    end
  end

  assign miso_o = out_reg;
  assign miso_oe_o = oe_reg;
  assign rx_byte_o = '{valid: rxv_reg, data: rxd_reg};
  assign tx_load_o = fall && cnt_reg == BIT_CNT_RST && !first_reg;
  assign selected_o = armed_reg && !sel_n_s;
  assign active_power_o = (armed_reg && !sel_n_s) || write_busy_i;
  assign frame_start_o = sel_fall;
  assign frame_end_o = sel_rise;
  assign wprot_n_o = wprot_s;

  // Main store and identification page; the lock is sticky until reset.
  logic [7:0] main_mem [ARRAY_DEPTH];
  logic [7:0] id_mem [IDPAGE_DEPTH];
  logic lock_reg, lock_next;
  logic [7:0] rdata_reg, rdata_next;

  // Lock update and read data selection.
  always_comb begin
    lock_next = lock_reg | id_lock_i;
    rdata_next = mem_id_i ? id_mem[mem_addr_i[4:0]] : main_mem[mem_addr_i];
  end

  // Arrays have no reset; a deep reset of a store would not be realistic.
  always_ff @(posedge core_clk_i) begin
    if (mem_we_i && !mem_id_i) begin
      main_mem[mem_addr_i] <= mem_wdata_i;
    end
    if (mem_we_i && mem_id_i && !lock_reg) begin
      id_mem[mem_addr_i[4:0]] <= mem_wdata_i;
    end
  end

  // Lock and read data registers.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_reg <= 1'b0;
      rdata_reg <= BYTE_RST;
    end else begin
      lock_reg <= lock_next;
      rdata_reg <= rdata_next;
    end
  end

  assign id_locked_o = lock_reg;
  assign mem_rdata_o = rdata_reg;

  // Output floats one cycle after select is high.
  desel_float_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sel_n_s |=> !miso_oe_o) else $error("output driven while deselected");

  // Pause releases the output one cycle later.
  pause_float_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !pause_n_s |=> !miso_oe_o) else $error("output driven in pause");

  // No byte before a first falling select edge.
  arm_first_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !armed_reg |=> !rx_byte_o.valid) else $error("byte before arming");

  // Select rise clears the counter.
  sel_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sel_rise |=> cnt_reg == BIT_CNT_RST) else $error("count not cleared");

  // Captured byte carries the last bit in bit 0.
  msb_first_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rise && cnt_reg == BIT_CNT_LAST |=> rx_byte_o.valid &&
    rx_byte_o.data[0] == $past(mosi_s)) else $error("bit order");

  // Output only changes after a falling clock edge.
  fall_shift_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !fall |=> $stable(miso_o)) else $error("output moved off edge");

  // Standby only when deselected with no write busy.
  power_mode_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    write_busy_i |-> active_power_o) else $error("standby in write");

  // Selection follows the select level once armed.
  select_lvl_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    armed_reg && !sel_n_s |-> selected_o && active_power_o)
    else $error("not selected");

  // Paused clock edges do not move the counter.
  pause_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !pause_n_s && !sel_rise && !sel_fall |=> $stable(cnt_reg))
    else $error("counted during pause");
endmodule // sef_front_end

//--- tb/sef_spi_master.sv
// Bus master model for the serial front end, clock mode 0,0 only.
// Assumes core_clk_i is the bench clock; pins move on its falling edge.
`timescale 1ns/10ps
module sef_spi_master (
  // Bench clock.
  input wire logic core_clk_i,
  // Serial pins to the device and data back.
  output sef_pkg::sef_pins_s pins_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  import sef_pkg::*;
  logic line_last = 1'b0;
  // A released line toggles, so a floating output never reads as held.
  wire logic line = miso_oe_i ? miso_i : ~line_last;
  always @(posedge core_clk_i) begin
    line_last <= line;
  end
  // Idle: clock low, deselected, no pause, writes allowed.
  initial begin
    pins_o = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  end
  // Half a link period of 32 ns.
  task automatic half();
    repeat (8) @(negedge core_clk_i);
  endtask
  // Select changes only with the clock held idle low.
  task automatic sel(input logic lvl);
    half();
    pins_o.sel_n = lvl;
    half();
  endtask
  // Shift n bits out MSB first and sample the reply on each rising edge.
  task automatic bits(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      pins_o.mosi = tx[i];
      half();
      pins_o.sclk = 1'b1;
      rx = {rx[6:0], line};
      half();
      pins_o.sclk = 1'b0;
    end
  endtask
  // Write protect level, given time to pass the synchroniser.
  task automatic wp(input logic lvl);
    pins_o.wprot_n = lvl;
    half();
  endtask
  // Pause is entered only while the device is selected.
  task automatic hold(input logic lvl);
    pins_o.pause_n = lvl;
  endtask
endmodule // sef_spi_master

//--- tb/tb_spi_eeprom_serial_front_end.sv
// Self-checking bench for the serial front end with a master model.
// Assumes the design's package and modules are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_spi_eeprom_serial_front_end;
  import sef_pkg::*;
  logic core_clk_i;
  logic sys_rst_i;
  sef_pins_s pins;
  sef_byte_s rx;
  logic miso, oe, tx_load, busy, lock, locked, selected, fstart, fend;
  logic act, we, mid, wprot;
  logic [7:0] tx_byte, wdata, rdata, got, r;
  logic [9:0] addr;
  int nrx, nld, nfs, nfe, fail_count, checks_done;
  // Clock of 4 ns period.
  always #2 core_clk_i = ~core_clk_i;
  // Keep the last received byte, since valid lasts only one cycle.
  always @(posedge core_clk_i) begin
    if (rx.valid === 1'b1) begin
      got <= rx.data;
      nrx <= nrx + 1;
    end
    if (tx_load === 1'b1) begin
      nld <= nld + 1;
    end
    if (fstart === 1'b1) begin
      nfs <= nfs + 1;
    end
    if (fend === 1'b1) begin
      nfe <= nfe + 1;
    end
  end
  sef_front_end dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .pins_i(pins), .miso_o(miso), .miso_oe_o(oe), .rx_byte_o(rx),
    .tx_byte_i(tx_byte), .tx_load_o(tx_load), .write_busy_i(busy),
    .id_lock_i(lock), .id_locked_o(locked), .selected_o(selected),
    .active_power_o(act), .frame_start_o(fstart), .frame_end_o(fend),
    .wprot_n_o(wprot), .mem_we_i(we), .mem_id_i(mid), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .mem_rdata_o(rdata));
  sef_spi_master mdl (.core_clk_i(core_clk_i), .pins_o(pins),
    .miso_i(miso), .miso_oe_i(oe));
  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock edges while deselected and unarmed must change nothing.
  task automatic t_idle();
    mdl.bits(8'hFF, 8, r);
    `CHK(nrx, 0);
    `CHK(oe, 1'b0);
    `CHK(act, 1'b0);
    `CHK(nfs, 0);
    mdl.wp(1'b0);
    `CHK(wprot, 1'b0);
    mdl.wp(1'b1);
    `CHK(wprot, 1'b1);
  endtask
  // One byte in, then one byte out while the next comes in.
  task automatic t_xfer();
    tx_byte = 8'h3C;
    mdl.sel(1'b0);
    `CHK({oe, selected, act}, 3'h7);
    mdl.bits(8'hA5, 8, r);
    `CHK(got, 8'hA5);
    mdl.bits(8'h5A, 8, r);
    `CHK(r, 8'h3C);
    `CHK(got, 8'h5A);
    `CHK(nrx, 2);
    mdl.sel(1'b1);
    `CHK({oe, selected}, 2'h0);
    `CHK(nld, 2);
    `CHK(nfs, 1);
    `CHK(nfe, 1);
  endtask
  // Clock edges during pause are ignored and the output floats.
  task automatic t_pause();
    mdl.sel(1'b0);
    mdl.bits(8'hC3, 4, r);
    mdl.hold(1'b0);
    mdl.bits(8'hFF, 3, r);
    `CHK(oe, 1'b0);
    mdl.hold(1'b1);
    mdl.half();
    mdl.bits(8'h30, 4, r);
    `CHK(got, 8'hC3);
    `CHK(nrx, 3);
    busy = 1'b1;
    mdl.sel(1'b1);
    `CHK(act, 1'b1);
    busy = 1'b0;
    mdl.half();
    `CHK(act, 1'b0);
  endtask
  // A partial byte is dropped when select rises.
  task automatic t_part();
    mdl.sel(1'b0);
    mdl.bits(8'hFF, 3, r);
    mdl.sel(1'b1);
    mdl.sel(1'b0);
    mdl.bits(8'h81, 8, r);
    `CHK(got, 8'h81);
    mdl.sel(1'b1);
  endtask
  // Store write and read, one cycle of read latency.
  task automatic mem(input logic id, input logic [9:0] a,
                     input logic w, input logic [7:0] d);
    @(negedge core_clk_i);
    {mid, addr, we, wdata} = {id, a, w, d};
    @(negedge core_clk_i);
    we = 1'b0;
    @(negedge core_clk_i);
  endtask
  // Top of the array, top of the id page, then the id page locked.
  task automatic t_mem();
    mem(1'b0, 10'h3FF, 1'b1, 8'h9E);
    mem(1'b1, 10'h01F, 1'b1, 8'h44);
    mem(1'b0, 10'h3FF, 1'b0, 8'h00);
    `CHK(rdata, 8'h9E);
    lock = 1'b1;
    mem(1'b1, 10'h01F, 1'b1, 8'h11);
    `CHK(locked, 1'b1);
    `CHK(rdata, 8'h44);
  endtask
  // Reset for four cycles, then the scenarios in turn.
  initial begin
    core_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    busy = 1'b0;
    lock = 1'b0;
    we = 1'b0;
    mid = 1'b0;
    tx_byte = 8'h00;
    wdata = 8'h00;
    got = 8'h00;
    addr = 10'h000;
    nrx = 0;
    nld = 0;
    nfs = 0;
    nfe = 0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_idle();
    t_xfer();
    t_pause();
    t_part();
    t_mem();
    give_verdict();
  end
  // Watchdog well beyond the expected run of about 3.6 us.
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule // tb_spi_eeprom_serial_front_end
